// ==== design/scg_top.sv ====
// Clock gating control: run, sleep and deep-sleep gating registers,
// selection of the applied set, unit access fault and fault interrupt.
// Assumes an APB master on I_CLK and power mode levels from the system.
//
// Operation
// - Gating bits 3, 16 and 20 are clock enables, set meaning clocked.
// - An access to a unit whose clock is off is answered with a fault.
// - Gating bits come out of reset clear, so every unit is unclocked.
// - Three gating sets exist, for run, sleep and deep sleep.
// - Sleep and deep-sleep sets replace the run set only with auto gate on.
// - Bit 16 is read/write, resets to 0 and gates the converter clock.
// - Bit 3 is read/write, resets to 0 and gates the watchdog clock.
// - Bits 9:8 pick the converter rate, 1 for 250K and 0 for 125K.
// - Reserved bits are read-only, read zero and are kept by software.
// - The whole register shows its printed reset value after reset.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
module scg_top (
    input  wire logic        I_CLK,
    input  wire logic        I_RST_N,
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [11:0] I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic      [31:0] O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    input  wire logic        I_SLEEP,
    input  wire logic        I_DEEP_SLEEP,
    input  wire logic [2:0]  I_UNIT_REQ,
    output logic      [2:0]  O_UNIT_FAULT,
    output logic             O_WDOG_CLK_EN,
    output logic             O_CONV_CLK_EN,
    output logic             O_PWM_CLK_EN,
    output logic      [1:0]  O_CONV_RATE_SEL,
    output logic             O_IRQ
);

    logic [31:0] run_val;
    logic [31:0] sleep_val;
    logic [31:0] deep_val;
    logic [31:0] cfg_val;
    logic        wr_acc;
    logic        rd_setup;
    logic        wr_run;
    logic        wr_sleep;
    logic        wr_deep;
    logic        wr_cfg;
    logic        hit;
    logic [31:0] rd_mux;
    logic [31:0] rdata_reg;
    logic        err_reg;
    logic        auto_gate;
    logic [31:0] sel_val;
    logic [2:0]  en_reg;
    logic [2:0]  en_next;
    logic [1:0]  rate_reg;
    logic [2:0]  fault;
    logic [2:0]  stat_reg;
    logic [2:0]  stat_next;
    logic [2:0]  mask_reg;
    logic        first_reg;

    scg_pkg::scg_mode_e mode_reg;
    scg_pkg::scg_mode_e mode_next;

    // Bus phases: writes commit in the access phase, reads are
    // captured in the setup phase so the data comes from a flip-flop
    assign wr_acc   = I_PSEL && I_PENABLE && I_PWRITE;
    assign rd_setup = I_PSEL && !I_PENABLE;
    assign wr_run   = wr_acc && (I_PADDR == scg_pkg::OFF_RUN_GATE);
    assign wr_sleep = wr_acc && (I_PADDR == scg_pkg::OFF_SLEEP_GATE);
    assign wr_deep  = wr_acc && (I_PADDR == scg_pkg::OFF_DEEP_GATE);
    assign wr_cfg   = wr_acc && (I_PADDR == scg_pkg::OFF_RUN_CFG);

    scg_gate_set #(
        .DATA_W  (32),
        .RST_VAL (scg_pkg::GATE_RESET),
        .WR_MASK (scg_pkg::GATE_WR_MASK)
    ) u_run (
        .i_clk   (I_CLK),
        .i_rst_n (I_RST_N),
        .i_wr    (wr_run),
        .i_wdata (I_PWDATA),
        .o_value (run_val)
    );

    // sleep register at printed reset value
    scg_gate_set #(
        .DATA_W  (32),
        .RST_VAL (scg_pkg::GATE_RESET),
        .WR_MASK (scg_pkg::GATE_WR_MASK)
    ) u_sleep (
        .i_clk   (I_CLK),
        .i_rst_n (I_RST_N),
        .i_wr    (wr_sleep),
        .i_wdata (I_PWDATA),
        .o_value (sleep_val)
    );

    scg_gate_set #(
        .DATA_W  (32),
        .RST_VAL (scg_pkg::GATE_RESET),
        .WR_MASK (scg_pkg::GATE_WR_MASK)
    ) u_deep (
        .i_clk   (I_CLK),
        .i_rst_n (I_RST_N),
        .i_wr    (wr_deep),
        .i_wdata (I_PWDATA),
        .o_value (deep_val)
    );

    // Auto gate select lives in the run config register
    scg_gate_set #(
        .DATA_W  (32),
        .RST_VAL (scg_pkg::CFG_RESET),
        .WR_MASK (scg_pkg::CFG_WR_MASK)
    ) u_cfg (
        .i_clk   (I_CLK),
        .i_rst_n (I_RST_N),
        .i_wr    (wr_cfg),
        .i_wdata (I_PWDATA),
        .o_value (cfg_val)
    );

    assign auto_gate = cfg_val[scg_pkg::BIT_AUTO_GATE];

    // low-power sets apply only with auto gate on
    always_comb
    begin
        mode_next = scg_pkg::MODE_RUN;
        if (auto_gate && I_DEEP_SLEEP)
        begin
            mode_next = scg_pkg::MODE_DEEP;
        end
        else if (auto_gate && I_SLEEP)
        begin
            mode_next = scg_pkg::MODE_SLEEP;
        end
    end

    // Applied mode
    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            mode_reg <= scg_pkg::MODE_RUN;
        end
        else
        begin
            mode_reg <= mode_next;
        end
    end

    // pick the set for the current mode
    always_comb
    begin
        case (mode_reg)
            scg_pkg::MODE_RUN:   sel_val = run_val;
            scg_pkg::MODE_SLEEP: sel_val = sleep_val;
            scg_pkg::MODE_DEEP:  sel_val = deep_val;
            default:             sel_val = run_val;
        endcase
    end

    always_comb
    begin
        en_next                     = 3'h0;
        en_next[scg_pkg::UNIT_WDOG] = sel_val[scg_pkg::BIT_WDOG];
        en_next[scg_pkg::UNIT_CONV] = sel_val[scg_pkg::BIT_CONV];
        en_next[scg_pkg::UNIT_PWM]  = sel_val[scg_pkg::BIT_PWM];
    end

    // enables and rate held off at reset
    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            en_reg   <= 3'h0;
            rate_reg <= scg_pkg::RATE_125K;
        end
        else
        begin
            en_reg   <= en_next;
            rate_reg <= sel_val[scg_pkg::RATE_HI:scg_pkg::RATE_LO];
        end
    end

    assign O_CONV_RATE_SEL = rate_reg;
    assign O_WDOG_CLK_EN   = en_reg[scg_pkg::UNIT_WDOG];
    assign O_CONV_CLK_EN   = en_reg[scg_pkg::UNIT_CONV];
    assign O_PWM_CLK_EN    = en_reg[scg_pkg::UNIT_PWM];

    // fault on access to an unclocked unit
    assign fault        = I_UNIT_REQ & ~en_reg;
    assign O_UNIT_FAULT = fault;

    // Fault events are sticky; a new fault beats a same-cycle clear
    always_comb
    begin
        stat_next = stat_reg;
        if (wr_acc && (I_PADDR == scg_pkg::OFF_IRQ_STAT))
        begin
            stat_next = stat_reg & ~I_PWDATA[2:0];
        end
        stat_next = stat_next | fault;
    end

    // Status and mask
    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            stat_reg <= 3'h0;
            mask_reg <= 3'h0;
        end
        else
        begin
            stat_reg <= stat_next;
            if (wr_acc && (I_PADDR == scg_pkg::OFF_IRQ_MASK))
            begin
                mask_reg <= I_PWDATA[2:0];
            end
        end
    end

    assign O_IRQ = |(stat_reg & mask_reg);

    // Read decode; unmapped addresses give an error
    always_comb
    begin
        hit    = 1'b1;
        rd_mux = 32'h0000_0000;
        case (I_PADDR)
            scg_pkg::OFF_RUN_GATE:   rd_mux = run_val;
            scg_pkg::OFF_SLEEP_GATE: rd_mux = sleep_val;
            scg_pkg::OFF_DEEP_GATE:  rd_mux = deep_val;
            scg_pkg::OFF_RUN_CFG:    rd_mux = cfg_val;
            scg_pkg::OFF_IRQ_STAT:   rd_mux = {29'h0, stat_reg};
            scg_pkg::OFF_IRQ_MASK:   rd_mux = {29'h0, mask_reg};
            default:                 hit = 1'b0;
        endcase
    end

    // Read data and error captured at setup, stable through access
    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            rdata_reg <= 32'h0000_0000;
            err_reg   <= 1'b0;
        end
        else if (rd_setup)
        begin
            rdata_reg <= I_PWRITE ? 32'h0000_0000 : rd_mux;
            err_reg   <= !hit;
        end
    end

    // Zero-wait slave: ready in every access phase
    assign O_PREADY  = I_PSEL && I_PENABLE;
    assign O_PSLVERR = I_PSEL && I_PENABLE && err_reg;
    assign O_PRDATA  = rdata_reg;

    // First cycle after reset release, for checks only
    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            first_reg <= 1'b1;
        end
        else
        begin
            first_reg <= 1'b0;
        end
    end

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_N);

    // reset value seen right after release
    property p_reset_value;
        first_reg |-> (sleep_val == scg_pkg::GATE_RESET) && (en_reg == 3'h0);
    endproperty
    a_reset_value: assert property (p_reset_value)
        else $error("sleep gating register not at reset value");

    property p_reset_off;
        first_reg |-> !O_WDOG_CLK_EN && !O_CONV_CLK_EN && !O_PWM_CLK_EN;
    endproperty
    a_reset_off: assert property (p_reset_off)
        else $error("unit clocked straight after reset");

    // watchdog access faults when its clock is off
    property p_wdog_fault;
        (I_UNIT_REQ[scg_pkg::UNIT_WDOG] && !O_WDOG_CLK_EN)
            |-> O_UNIT_FAULT[scg_pkg::UNIT_WDOG] ##1 stat_reg[scg_pkg::UNIT_WDOG];
    endproperty
    a_wdog_fault: assert property (p_wdog_fault)
        else $error("watchdog access while unclocked not faulted");

    // pulse-width unit faults only when unclocked
    property p_pwm_fault;
        I_UNIT_REQ[scg_pkg::UNIT_PWM]
            |-> (O_UNIT_FAULT[scg_pkg::UNIT_PWM] == !O_PWM_CLK_EN);
    endproperty
    a_pwm_fault: assert property (p_pwm_fault)
        else $error("pulse-width fault does not follow its enable");

    // fault exactly where a requested unit is unclocked
    property p_no_false_fault;
        O_UNIT_FAULT == (I_UNIT_REQ & ~{O_PWM_CLK_EN, O_CONV_CLK_EN, O_WDOG_CLK_EN});
    endproperty
    a_no_false_fault: assert property (p_no_false_fault)
        else $error("fault raised for a clocked or idle unit");

    // without auto gate the run set drives the enables; the mode
    // register lags auto gate by one cycle, hence the extra step
    property p_run_only;
        !auto_gate ##1 1'b1 |=> (O_CONV_CLK_EN == $past(run_val[scg_pkg::BIT_CONV]))
            && (O_WDOG_CLK_EN == $past(run_val[scg_pkg::BIT_WDOG]));
    endproperty
    a_run_only: assert property (p_run_only)
        else $error("low-power set applied without auto gate");

    // sleep set applied in sleep with auto gate
    property p_sleep_set;
        (auto_gate && I_SLEEP && !I_DEEP_SLEEP) ##1 (mode_reg == scg_pkg::MODE_SLEEP)
            |=> (O_PWM_CLK_EN == $past(sleep_val[scg_pkg::BIT_PWM]))
            && (O_CONV_RATE_SEL == $past(sleep_val[scg_pkg::RATE_HI:scg_pkg::RATE_LO]));
    endproperty
    a_sleep_set: assert property (p_sleep_set)
        else $error("sleep gating set not applied in sleep");

    // converter bit written through the bus
    property p_conv_write;
        wr_sleep |=> (sleep_val[scg_pkg::BIT_CONV] == $past(I_PWDATA[scg_pkg::BIT_CONV]))
            && (sleep_val[scg_pkg::RATE_HI:scg_pkg::RATE_LO]
                == $past(I_PWDATA[scg_pkg::RATE_HI:scg_pkg::RATE_LO]));
    endproperty
    a_conv_write: assert property (p_conv_write)
        else $error("sleep register write lost");

    // reserved bits never read back set
    property p_reserved_zero;
        (O_PREADY && !I_PWRITE && (I_PADDR == scg_pkg::OFF_SLEEP_GATE))
            |-> ((O_PRDATA & ~scg_pkg::GATE_RD_MASK) == 32'h0000_0000);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved sleep register bit reads set");

endmodule

// ==== design/scg_pkg.sv ====
// Package for the sleep clock gating block: register map, field layout,
// reset values and mode codes.
// Assumes a 32-bit APB register bus with one aligned word per register.
package scg_pkg;

    // Register byte offsets
    localparam logic [11:0] OFF_RUN_GATE   = 12'h100;
    localparam logic [11:0] OFF_SLEEP_GATE = 12'h110;
    localparam logic [11:0] OFF_DEEP_GATE  = 12'h120;
    localparam logic [11:0] OFF_RUN_CFG    = 12'h060;
    localparam logic [11:0] OFF_IRQ_STAT   = 12'h130;
    localparam logic [11:0] OFF_IRQ_MASK   = 12'h134;

    // Gating register field positions
    localparam int BIT_WDOG     = 3;
    localparam int BIT_FIXED1   = 6;
    localparam int RATE_LO      = 8;
    localparam int RATE_HI      = 9;
    localparam int BIT_CONV     = 16;
    localparam int BIT_PWM      = 20;

    // Config register field position
    localparam int BIT_AUTO_GATE = 0;

    // Unit index inside enable and fault vectors
    localparam int UNIT_WDOG = 0;
    localparam int UNIT_CONV = 1;
    localparam int UNIT_PWM  = 2;
    localparam int UNIT_N    = 3;

    // Reset value and writable bits of each gating register
    localparam logic [31:0] GATE_RESET   = 32'h0000_0040;
    localparam logic [31:0] GATE_WR_MASK = 32'h0011_0308;
    localparam logic [31:0] GATE_RD_MASK = 32'h0011_0348;
    localparam logic [31:0] CFG_RESET    = 32'h0000_0000;
    localparam logic [31:0] CFG_WR_MASK  = 32'h0000_0001;

    // Sample rate codes
    localparam logic [1:0] RATE_125K = 2'h0;
    localparam logic [1:0] RATE_250K = 2'h1;

    // Which gating set is applied
    typedef enum logic [1:0] {
        MODE_RUN   = 2'b00,
        MODE_SLEEP = 2'b01,
        MODE_DEEP  = 2'b10
    } scg_mode_e;

endpackage

// ==== design/scg_gate_set.sv ====
// One software-written register with fixed read-only bits.
// Assumes the caller decodes the bus and gives a one-cycle write strobe.
`timescale 1ns/100ps
module scg_gate_set #(
    parameter int          DATA_W  = 32,
    parameter logic [31:0] RST_VAL = 32'h0000_0000,
    parameter logic [31:0] WR_MASK = 32'h0000_0000
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_wr,
    input  wire logic [DATA_W-1:0] i_wdata,
    output logic      [DATA_W-1:0] o_value
);

    logic [DATA_W-1:0] store_reg;
    logic [DATA_W-1:0] store_next;

    // Only a full 32-bit word maps onto the register layout
    if (DATA_W != 32)
    begin : g_width_check
        $error("scg_gate_set needs DATA_W of 32");
    end

    // Writable bits take the bus data, the rest keep their fixed value
    always_comb
    begin
        store_next = store_reg;
        if (i_wr)
        begin
            store_next = (i_wdata & WR_MASK) | (RST_VAL & ~WR_MASK);
        end
    end

    // Storage, reset to the printed value
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            store_reg <= RST_VAL;
        end
        else
        begin
            store_reg <= store_next;
        end
    end

    // Reserved bits can never be altered by software
    assign o_value = store_reg;

endmodule

// ==== test/tb_top.sv ====
// Self-checking bench for the clock gating block: reset values, register
// access, gating set selection, unit faults and the fault interrupt.
// Assumes the design answers APB with zero wait states, as handed over.
`timescale 1ns/100ps
module tb_top;
    logic        I_CLK        = 1'b0;
    logic        I_RST_N      = 1'b0;
    logic        I_PSEL       = 1'b0;
    logic        I_PENABLE    = 1'b0;
    logic        I_PWRITE     = 1'b0;
    logic [11:0] I_PADDR      = 12'h000;
    logic [31:0] I_PWDATA     = 32'h0000_0000;
    logic        I_SLEEP      = 1'b0;
    logic        I_DEEP_SLEEP = 1'b0;
    logic [2:0]  I_UNIT_REQ   = 3'h0;
    logic [31:0] O_PRDATA;
    logic        O_PREADY;
    logic        O_PSLVERR;
    logic [2:0]  O_UNIT_FAULT;
    logic        O_WDOG_CLK_EN;
    logic        O_CONV_CLK_EN;
    logic        O_PWM_CLK_EN;
    logic [1:0]  O_CONV_RATE_SEL;
    logic        O_IRQ;
    int          n_errors     = 0;
    int          n_tests      = 0;
    int          n_cyc        = 0;
    logic [32:0] exp_q[$];
    logic [31:0] seed         = 32'h1dda;
    logic [31:0] va;
    logic [31:0] vb;
    logic [31:0] vc;

    scg_top i_scg_top (
        .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
        .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
        .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
        .I_SLEEP(I_SLEEP), .I_DEEP_SLEEP(I_DEEP_SLEEP), .I_UNIT_REQ(I_UNIT_REQ),
        .O_UNIT_FAULT(O_UNIT_FAULT), .O_WDOG_CLK_EN(O_WDOG_CLK_EN),
        .O_CONV_CLK_EN(O_CONV_CLK_EN), .O_PWM_CLK_EN(O_PWM_CLK_EN),
        .O_CONV_RATE_SEL(O_CONV_RATE_SEL), .O_IRQ(O_IRQ)
    );

    // Free-running 100 MHz clock
    always #5 I_CLK = ~I_CLK;

    // Pseudo-random source, fixed start for repeatable runs
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Readback of a gating register after a write of d
    function automatic logic [31:0] gate_rb(input logic [31:0] d);
        return (d & scg_pkg::GATE_WR_MASK) | scg_pkg::GATE_RESET;
    endfunction

    task automatic stop_test();
        $display("errors %0d, comparisons %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic cmp_bus(input logic [32:0] got, input logic [32:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %0t bus answer %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_port(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %0t port value %h, expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; the expected answer is noted for the monitor
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] ed, input logic ee);
        exp_q.push_back({ee, ed});
        @(posedge I_CLK);
        I_PSEL    <= 1'b1;
        I_PWRITE  <= w;
        I_PADDR   <= a;
        I_PWDATA  <= d;
        @(posedge I_CLK);
        I_PENABLE <= 1'b1;
        // Wait states are allowed; only the bench timeout ends a hang
        do
        begin
            @(posedge I_CLK);
        end
        while (O_PREADY !== 1'b1);
        I_PSEL    <= 1'b0;
        I_PENABLE <= 1'b0;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge I_CLK);
    endtask

    // Enables and rate against the fields of the applied gating register
    task automatic chk_en(input logic [31:0] v);
        cmp_port(32'({O_PWM_CLK_EN, O_CONV_CLK_EN, O_WDOG_CLK_EN, O_CONV_RATE_SEL}),
                 32'({v[20], v[16], v[3], v[9:8]}));
    endtask

    // Monitor: each completed transfer takes the oldest note; data only on reads
    always @(posedge I_CLK)
    begin
        if (I_RST_N && I_PSEL && I_PENABLE && O_PREADY === 1'b1 && exp_q.size() > 0)
        begin
            if (I_PWRITE)
                cmp_bus({O_PSLVERR, 32'h0}, {exp_q[0][32], 32'h0});
            else
                cmp_bus({O_PSLVERR, O_PRDATA}, exp_q[0]);
            void'(exp_q.pop_front());
        end
    end

    // Hang guard, far above the length of the sequence
    always @(posedge I_CLK)
    begin
        n_cyc++;
        if (n_cyc >= 5000)
        begin
            n_errors++;
            $display("CHECK FAILED %0t run did not finish", $time);
            stop_test();
        end
    end

    initial
    begin
        wait_cyc(5);
        I_RST_N <= 1'b1;
        // Reset values of all three sets and of the config register
        apb(0, scg_pkg::OFF_RUN_GATE, 0, scg_pkg::GATE_RESET, 0);
        apb(0, scg_pkg::OFF_SLEEP_GATE, 0, 32'h0000_0040, 0);
        apb(0, scg_pkg::OFF_DEEP_GATE, 0, scg_pkg::GATE_RESET, 0);
        apb(0, scg_pkg::OFF_RUN_CFG, 0, 32'h0, 0);
        chk_en(32'h0);
        // Reserved bits ignore ones and zeros alike
        apb(1, scg_pkg::OFF_SLEEP_GATE, 32'hffff_ffff, 0, 0);
        apb(0, scg_pkg::OFF_SLEEP_GATE, 0, 32'h0011_0348, 0);
        apb(1, scg_pkg::OFF_SLEEP_GATE, 32'h0, 0, 0);
        apb(0, scg_pkg::OFF_SLEEP_GATE, 0, 32'h0000_0040, 0);
        // Unmapped places answer with an error
        apb(0, 12'h200, 0, 32'h0, 1);
        apb(1, 12'h204, 32'hffff_ffff, 0, 1);
        // Random contents for three distinct sets
        seed = lfsr_next(seed);
        // Rate bit 9 kept clear: only the two legal rate codes are written
        va = seed & ~32'h0000_0200;
        vb = ~va & ~32'h0000_0200;
        vc = va ^ 32'h0001_0100;
        apb(1, scg_pkg::OFF_RUN_GATE, va, 0, 0);
        apb(1, scg_pkg::OFF_SLEEP_GATE, vb, 0, 0);
        apb(1, scg_pkg::OFF_DEEP_GATE, vc, 0, 0);
        apb(0, scg_pkg::OFF_SLEEP_GATE, 0, gate_rb(vb), 0);
        wait_cyc(4);
        chk_en(va);
        // Sleep without auto select keeps the run set
        I_SLEEP <= 1'b1;
        wait_cyc(4);
        chk_en(va);
        apb(1, scg_pkg::OFF_RUN_CFG, 32'hffff_ffff, 0, 0);
        apb(0, scg_pkg::OFF_RUN_CFG, 0, 32'h1, 0);
        wait_cyc(4);
        chk_en(vb);
        // Both rate codes pass through the applied sleep set
        for (int r = 0; r < 2; r++)
        begin
            apb(1, scg_pkg::OFF_SLEEP_GATE, 32'(r) << 8, 0, 0);
            wait_cyc(4);
            cmp_port(32'(O_CONV_RATE_SEL), 32'(r));
        end
        apb(1, scg_pkg::OFF_SLEEP_GATE, vb, 0, 0);
        I_DEEP_SLEEP <= 1'b1;
        wait_cyc(4);
        chk_en(vc);
        I_SLEEP      <= 1'b0;
        I_DEEP_SLEEP <= 1'b0;
        wait_cyc(4);
        chk_en(va);
        // Faults with every unit unclocked, then status and interrupt
        apb(1, scg_pkg::OFF_RUN_GATE, 32'h0, 0, 0);
        apb(1, scg_pkg::OFF_IRQ_MASK, 32'h1, 0, 0);
        wait_cyc(3);
        I_UNIT_REQ <= 3'h7;
        wait_cyc(2);
        cmp_port(32'(O_UNIT_FAULT), 32'h7);
        I_UNIT_REQ <= 3'h0;
        apb(0, scg_pkg::OFF_IRQ_STAT, 0, 32'h7, 0);
        wait_cyc(1);
        cmp_port(32'(O_IRQ), 32'h1);
        apb(1, scg_pkg::OFF_IRQ_MASK, 32'h0, 0, 0);
        wait_cyc(1);
        cmp_port(32'(O_IRQ), 32'h0);
        apb(1, scg_pkg::OFF_IRQ_STAT, 32'h7, 0, 0);
        apb(0, scg_pkg::OFF_IRQ_STAT, 0, 32'h0, 0);
        // Watchdog clocked, other two still fault
        apb(1, scg_pkg::OFF_RUN_GATE, 32'h0000_0008, 0, 0);
        wait_cyc(4);
        I_UNIT_REQ <= 3'h7;
        wait_cyc(2);
        cmp_port(32'(O_UNIT_FAULT), 32'h6);
        // Clear while the converter keeps faulting: the new event wins
        I_UNIT_REQ <= 3'h2;
        apb(1, scg_pkg::OFF_IRQ_STAT, 32'h7, 0, 0);
        apb(0, scg_pkg::OFF_IRQ_STAT, 0, 32'h2, 0);
        I_UNIT_REQ <= 3'h0;
        wait_cyc(3);
        // Every noted bus answer must have been seen
        if (exp_q.size() != 0)
        begin
            n_errors++;
            $display("CHECK FAILED %0t bus answers missing", $time);
        end
        stop_test();
    end
endmodule
